//--- inc/pa_regs.vh
`ifndef PA_REGS_VH
`define PA_REGS_VH
// Register byte addresses
`define PA_ADDR_W           8
`define PA_OFS_IRQ_EN_TWO   8'h24
`define PA_OFS_IRQ_FLAGS    8'h25
`define PA_OFS_ACC_CTRL     8'h26
`define PA_OFS_ACC_COUNT    8'h27
// Mask and flag bit positions
`define PA_BIT_MAIN_OVF     7
`define PA_BIT_PERIODIC     6
`define PA_BIT_ACC_OVF      5
`define PA_BIT_ACC_EDGE     4
// Control bit positions
`define PA_BIT_ACC_EN       6
`define PA_BIT_ACC_GATED    5
`define PA_BIT_ACC_EDGESEL  4
`define PA_BIT_CAP4_SEL     2
// Reset values
`define PA_RST_IRQ_EN       8'h00
`define PA_RST_FLAGS        4'h0
`define PA_RST_CTRL         8'h00
// Implemented-bit masks
`define PA_MASK_IRQ_EN      8'hF3
`define PA_MASK_CTRL        8'h77
// Timing: periodic base is E/2^12, gated tick is E/64
`define PA_PERIODIC_BASE_W  12
`define PA_PERIODIC_DIV_W   15
`define PA_GATED_DIV        64
`define PA_GATED_DIV_W      6
`endif

//--- core/pa_core.v
// Overview of operation
// RULE1 - Mask bits 7..4 pair with flag bits 7..4 and gate their requests.
// RULE2 - Periodic interrupt requested when periodic flag set and its enable is one.
// RULE3 - Flag register write clears flags written one, keeps others.
// RULE4 - Main overflow flag set when main timer wraps from all ones to zero.
// RULE5 - Periodic flag set at close of every periodic interval.
// RULE6 - Periodic interval derived from free E/4096 tick, independent of main prescaler.
// RULE7 - Rate select picks 2^12, 2^13, 2^14 or 2^15 E cycles.
// RULE8 - Divider runs freely, times from previous timeout, full interval before first flag.
// RULE9 - Unimplemented bits read zero: flag bits 3..0, control bits 7 and 3.
// RULE10 - Accumulator enable bit turns the pulse accumulator on or off.
// RULE11 - Gated select one picks gated time mode, zero picks event counting.
// RULE12 - Edge select: falling/rising in event mode; low/high inhibits in gated mode.
// RULE13 - Gated mode counts E/64 ticks only while pin is at active level.
// RULE14 - External pin source must not toggle faster than half the E rate.
// RULE15 - Count readable and writable any time; reset leaves it untouched.
// RULE16 - Increments never collide with a software read of the count.
// RULE17 - Accumulator overflow flag set on wrap FF to 00, cleared by writing bit 5.
// RULE18 - Overflow enable only gates request; a flag setting raises a request only while enabled.
// RULE19 - Edge flag set on each selected pin edge, cleared by writing bit 4.
// RULE20 - Edge enable only gates request; flag set and clear unaffected.
// RULE21 - Service software must clear serviced flag by writing one before returning.
// RULE22 - Control bit 2 picks capture four when one, compare five when zero.
// RULE23 - Disabled accumulator neither counts nor sets flags from pin; writes still work.
// RULE24 - Each source request is its flag ANDed with its mask, held as a level.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "pa_regs.vh"
module pa_core
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [7:0]  rdata_ff,
  input  wire        acc_input_pin,
  input  wire        main_timer_wrap,
  output reg  [1:0]  main_prescale_sel_ff,
  output reg         capture4_compare5_select_ff,
  output reg         main_overflow_irq_ff,
  output reg         periodic_irq_ff,
  output reg         acc_overflow_irq_ff,
  output reg         acc_edge_irq_ff,
  output reg         periodic_tick_ff
);

  reg  [7:0]                     irq_en_ff;
  reg  [7:4]                     flags_ff;
  reg  [7:0]                     ctrl_ff;
  reg  [7:0]                     acc_count_ff;
  reg  [`PA_PERIODIC_DIV_W-1:0]  per_div_ff;
  reg  [`PA_GATED_DIV_W-1:0]     gate_div_ff;
  reg  [2:0]                     pin_sync_ff;
  reg                            pin_state_ff;
  reg                            per_done_ff;
  reg  [7:4]                     nxt_flags;
  reg  [7:0]                     nxt_acc_count;
  reg  [7:0]                     nxt_rdata;
  reg                            per_hit;
  wire                           wr_irq_en;
  wire                           wr_flags;
  wire                           wr_ctrl;
  wire                           wr_count;
  wire                           acc_en;
  wire                           acc_gated;
  wire                           acc_edgesel;
  wire                           pin_stable;
  wire                           pin_rise;
  wire                           pin_fall;
  wire                           sel_edge;
  wire                           gate_tick;
  wire                           gate_active;
  wire                           acc_inc;
  wire                           acc_wrap;
  wire [1:0]                     rate_sel;
  wire [`PA_PERIODIC_DIV_W-1:0]  per_div_inc;

  // Address decode of the four byte registers
  assign wr_irq_en   = wr_en && (addr == `PA_OFS_IRQ_EN_TWO);
  assign wr_flags    = wr_en && (addr == `PA_OFS_IRQ_FLAGS);
  assign wr_ctrl     = wr_en && (addr == `PA_OFS_ACC_CTRL);
  assign wr_count    = wr_en && (addr == `PA_OFS_ACC_COUNT);
  assign acc_en      = ctrl_ff[`PA_BIT_ACC_EN];
  assign acc_gated   = ctrl_ff[`PA_BIT_ACC_GATED];
  assign acc_edgesel = ctrl_ff[`PA_BIT_ACC_EDGESEL];
  assign rate_sel    = ctrl_ff[1:0];

  // Mask and control registers, unimplemented bits never stored
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en_ff <= `PA_RST_IRQ_EN;
      ctrl_ff   <= `PA_RST_CTRL;
    end
    else
    begin
      if (wr_irq_en)
        irq_en_ff <= wdata & `PA_MASK_IRQ_EN;
      if (wr_ctrl)
        ctrl_ff <= wdata & `PA_MASK_CTRL;  // [RULE9]
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync_ff  <= 3'b000;
      pin_state_ff <= 1'b0;
    end
    else
    begin
      pin_sync_ff <= {pin_sync_ff[1:0], acc_input_pin};
      if (pin_stable)
        pin_state_ff <= pin_sync_ff[2];
    end
  end

  assign pin_stable = (pin_sync_ff[1] == pin_sync_ff[2]);
  // Edges of the filtered level; source rate limited to E/2 outside [RULE14]
  assign pin_rise   = pin_stable && pin_sync_ff[2] && !pin_state_ff;
  assign pin_fall   = pin_stable && !pin_sync_ff[2] && pin_state_ff;
  assign sel_edge   = acc_edgesel ? pin_rise : pin_fall;  // [RULE12]

  // Free-running E/64 tick for gated accumulation
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_div_ff <= {`PA_GATED_DIV_W{1'b0}};
    else
      gate_div_ff <= gate_div_ff + {{(`PA_GATED_DIV_W-1){1'b0}}, 1'b1};
  end

  assign gate_tick   = (gate_div_ff == {`PA_GATED_DIV_W{1'b1}});  // [RULE13]
  // Edge select one inhibits on high, zero inhibits on low
  assign gate_active = acc_edgesel ? !pin_state_ff : pin_state_ff;  // [RULE12]
  // Mode choice and enable gate the increment
  assign acc_inc  = acc_en && (acc_gated ? (gate_tick && gate_active) : sel_edge);  // [RULE10] [RULE11] [RULE23]
  assign acc_wrap = acc_inc && !wr_count && (acc_count_ff == 8'hFF);

  // Count next value; a software write takes the cycle over the increment
  always @*
  begin
    nxt_acc_count = acc_count_ff;
    if (wr_count)
      nxt_acc_count = wdata;  // [RULE15] [RULE23]
    else if (acc_inc)
      nxt_acc_count = acc_count_ff + 8'h01;
  end

  // Count has no reset so its contents survive reset
  always @(posedge clk)
  begin
    acc_count_ff <= nxt_acc_count;  // [RULE15] [RULE16]
  end

  // Free-running periodic divider, cleared only by reset
  assign per_div_inc = per_div_ff + {{(`PA_PERIODIC_DIV_W-1){1'b0}}, 1'b1};

  always @*
  begin
    case (rate_sel)
      2'b00:   per_hit = (per_div_ff[`PA_PERIODIC_BASE_W-1:0] == {`PA_PERIODIC_BASE_W{1'b1}});
      2'b01:   per_hit = (per_div_ff[`PA_PERIODIC_BASE_W:0] == {(`PA_PERIODIC_BASE_W+1){1'b1}});
      2'b10:   per_hit = (per_div_ff[`PA_PERIODIC_BASE_W+1:0] == {(`PA_PERIODIC_BASE_W+2){1'b1}});
      default: per_hit = (per_div_ff == {`PA_PERIODIC_DIV_W{1'b1}});
    endcase  // [RULE6] [RULE7]
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_div_ff  <= {`PA_PERIODIC_DIV_W{1'b0}};
      per_done_ff <= 1'b0;
    end
    else
    begin
      per_div_ff  <= per_div_inc;  // [RULE8]
      per_done_ff <= per_hit;
    end
  end

  // Flag update: hardware sets win over a same-cycle write-one clear
  always @*
  begin
    nxt_flags = flags_ff;
    if (wr_flags)
      nxt_flags = flags_ff & ~wdata[7:4];  // [RULE3]
    if (main_timer_wrap)
      nxt_flags[`PA_BIT_MAIN_OVF] = 1'b1;  // [RULE4]
    if (per_done_ff)
      nxt_flags[`PA_BIT_PERIODIC] = 1'b1;  // [RULE5] [RULE8]
    if (acc_wrap)
      nxt_flags[`PA_BIT_ACC_OVF] = 1'b1;  // [RULE17]
    if (acc_en && sel_edge)
      nxt_flags[`PA_BIT_ACC_EDGE] = 1'b1;  // [RULE19] [RULE23]
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_ff <= `PA_RST_FLAGS;
    else
      flags_ff <= nxt_flags;
  end

  // Level requests: flag AND mask, held until either clears
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_overflow_irq_ff <= 1'b0;
      periodic_irq_ff      <= 1'b0;
      acc_overflow_irq_ff  <= 1'b0;
      acc_edge_irq_ff      <= 1'b0;
    end
    else
    begin
      main_overflow_irq_ff <= flags_ff[`PA_BIT_MAIN_OVF] & irq_en_ff[`PA_BIT_MAIN_OVF];  // [RULE1] [RULE24]
      periodic_irq_ff      <= flags_ff[`PA_BIT_PERIODIC] & irq_en_ff[`PA_BIT_PERIODIC];  // [RULE2]
      acc_overflow_irq_ff  <= flags_ff[`PA_BIT_ACC_OVF] & irq_en_ff[`PA_BIT_ACC_OVF];    // [RULE18] [RULE21]
      acc_edge_irq_ff      <= flags_ff[`PA_BIT_ACC_EDGE] & irq_en_ff[`PA_BIT_ACC_EDGE];  // [RULE20] [RULE21]
    end
  end

  // Side outputs for neighbouring timer units
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_prescale_sel_ff        <= 2'b00;
      capture4_compare5_select_ff <= 1'b0;
      periodic_tick_ff            <= 1'b0;
    end
    else
    begin
      main_prescale_sel_ff        <= irq_en_ff[1:0];
      capture4_compare5_select_ff <= ctrl_ff[`PA_BIT_CAP4_SEL];  // [RULE22]
      periodic_tick_ff            <= per_hit;
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    case (addr)
      `PA_OFS_IRQ_EN_TWO: nxt_rdata = irq_en_ff;
      `PA_OFS_IRQ_FLAGS:  nxt_rdata = {flags_ff, 4'h0};  // [RULE9]
      `PA_OFS_ACC_CTRL:   nxt_rdata = ctrl_ff;
      `PA_OFS_ACC_COUNT:  nxt_rdata = acc_count_ff;     // [RULE15]
      default:            nxt_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (rd_en)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 8'h00;
  end

endmodule

//--- dv/pa_core_checker.sv
`timescale 1ns/10ps
module pa_core_checker
(
  input wire       clk,
  input wire       rst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] rdata_ff,
  input wire       main_timer_wrap,
  input wire       capture4_compare5_select_ff,
  input wire       main_overflow_irq_ff,
  input wire       periodic_irq_ff,
  input wire       periodic_tick_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg  [7:0]  msk_ff;
  reg  [15:0] gap_ff;
  reg         gap_ok_ff;
  wire        wr_irq = wr_en && addr[7:1] == 7'h12;
  // Mask shadow and tick spacing; rate writes spoil one gap
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      msk_ff    <= 8'h00;
      gap_ff    <= 16'h0000;
      gap_ok_ff <= 1'b0;
    end
    else
    begin
      if (wr_en && addr == 8'h24)
        msk_ff <= wdata;
      gap_ff    <= periodic_tick_ff ? 16'h0000 : gap_ff + 16'h0001;
      gap_ok_ff <= (wr_en && addr == 8'h26) ? 1'b0 : (gap_ok_ff | periodic_tick_ff);
    end
  a_tick_single: assert property (periodic_tick_ff |=> !periodic_tick_ff)
    else $error("tick too wide");
  a_tick_gap: assert property (periodic_tick_ff && gap_ok_ff |->
    gap_ff inside {16'h0fff, 16'h1fff, 16'h3fff, 16'h7fff}) else $error("bad tick spacing");
  a_flag_low_zero: assert property (rd_en && addr == 8'h25 |=> rdata_ff[3:0] == 4'h0)
    else $error("flag low bits set");
  a_ctrl_gap_zero: assert property (rd_en && addr == 8'h26 |=> !rdata_ff[7] && !rdata_ff[3])
    else $error("ctrl spare bits set");
  a_rti_masked: assert property (wr_en && addr == 8'h24 && !wdata[6] |-> ##2 !periodic_irq_ff)
    else $error("periodic request unmasked");
  a_w1c_clear: assert property (wr_en && addr == 8'h25 && wdata[7] && !main_timer_wrap |->
    ##2 !main_overflow_irq_ff) else $error("overflow flag not cleared");
  a_wrap_sets: assert property (main_timer_wrap && msk_ff[7] && !(wr_en && addr == 8'h24) |->
    ##2 main_overflow_irq_ff) else $error("wrap gave no request");
  a_irq_holds: assert property (periodic_irq_ff && !$past(wr_irq) |=> periodic_irq_ff)
    else $error("request dropped");
  a_sel_follows: assert property (wr_en && addr == 8'h26 |->
    ##2 capture4_compare5_select_ff == $past(wdata[2], 2)) else $error("select copy wrong");
endmodule

//--- dv/pa_pin_model.sv
`timescale 1ns/10ps
module pa_pin_model
(
  input wire clk,
  input wire want,
  output reg pin
);
  reg [3:0] hold_ff = 4'h0;
  initial pin = 1'b0;
  // Follow the wanted level, keeping each level several clocks
  always @(posedge clk)
    if (hold_ff != 4'h0)
      hold_ff <= hold_ff - 4'h1;
    else if (want != pin)
    begin
      pin     <= want;
      hold_ff <= 4'h7;
    end
endmodule

//--- dv/pa_core_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t mismatch", $time); end end
module pa_core_tb_top;
  reg        clk, rst_n, wr_en, rd_en, main_timer_wrap, want;
  reg  [7:0] addr, wdata, rv;
  reg [31:0] r;
  wire [7:0] rdata_ff;
  wire [1:0] main_prescale_sel_ff;
  wire       c45_sel, ovf_irq, per_irq, acc_ovf_irq, acc_edge_irq, tick, acc_input_pin;
  int        fail_count, cmp_count, cyc, t0, t1, s;
  pa_core i_pa_core (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_ff(rdata_ff), .acc_input_pin(acc_input_pin), .main_timer_wrap(main_timer_wrap),
    .main_prescale_sel_ff(main_prescale_sel_ff), .capture4_compare5_select_ff(c45_sel),
    .main_overflow_irq_ff(ovf_irq), .periodic_irq_ff(per_irq), .acc_overflow_irq_ff(acc_ovf_irq),
    .acc_edge_irq_ff(acc_edge_irq), .periodic_tick_ff(tick));
  pa_pin_model i_pa_pin_model (.clk(clk), .want(want), .pin(acc_input_pin));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (rst_n) cyc <= cyc + 1;
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rdc(input [7:0] a, input [7:0] m, input [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rdata_ff;
    `CHK(rv & m, e)
  endtask
  task pulse;
    @(posedge clk) want <= 1'b1;
    repeat (12) @(posedge clk);
    want <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // Spacing is measured tick to tick, since the divider never restarts
  task wait_tick;
    do @(posedge clk); while (tick !== 1'b1);
    t0 = t1;
    t1 = cyc;
    #1;
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    {rst_n, wr_en, rd_en, main_timer_wrap, want, addr, wdata} = 0;
    r = $urandom(30292);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h25, 8'hff, 8'h00);
    rdc(8'h3a, 8'hff, 8'h00);
    wr(8'h24, 8'h40);
    wr(8'h26, 8'h03);
    wait_tick;
    `CHK(cyc >= 32767, 1'b1)
    for (s = 2; s >= 0; s--)
    begin
      wr(8'h26, s[7:0]);
      wait_tick;
      `CHK(t1 - t0, 4096 << s)
    end
    wait_tick;
    `CHK(t1 - t0, 4096)
    `CHK(per_irq, 1'b1)
    rdc(8'h25, 8'h40, 8'h40);
    wr(8'h25, 8'h40);
    repeat (2) @(posedge clk);
    #1 `CHK(per_irq, 1'b0)
    $display("test periodic done");
    r = $urandom;
    wr(8'h24, {4'h9, r[3:0]});
    rdc(8'h24, 8'hff, {4'h9, 2'b00, r[1:0]});
    `CHK(main_prescale_sel_ff, r[1:0])
    @(posedge clk) main_timer_wrap <= 1'b1;
    @(posedge clk) main_timer_wrap <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(ovf_irq, 1'b1)
    wr(8'h25, 8'h80);
    r = $urandom;
    wr(8'h26, r[7:0]);
    rdc(8'h26, 8'hff, r[7:0] & 8'h77);
    `CHK(c45_sel, r[2])
    wr(8'h26, 8'h00);
    wr(8'h25, 8'h30);
    wr(8'h27, r[15:8]);
    pulse;
    rdc(8'h27, 8'hff, r[15:8]);
    rdc(8'h25, 8'h30, 8'h00);
    $display("test registers done");
    for (s = 0; s < 2; s++)
    begin
      wr(8'h24, {2'b10, s[0], 5'h10});
      wr(8'h26, {3'b010, s[0], 4'h0});
      wr(8'h27, 8'hfe);
      pulse;
      pulse;
      rdc(8'h27, 8'hff, 8'h00);
      rdc(8'h25, 8'h30, 8'h30);
      `CHK(acc_edge_irq, 1'b1)
      `CHK(acc_ovf_irq, s[0])
      wr(8'h25, 8'h10);
      rdc(8'h25, 8'h30, 8'h20);
      wr(8'h25, 8'h20);
    end
    $display("test event done");
    for (s = 0; s < 2; s++)
    begin
      wr(8'h26, {3'b011, s[0], 4'h0});
      @(posedge clk) want <= s[0];
      repeat (16) @(posedge clk);
      wr(8'h27, 8'h00);
      repeat (640) @(posedge clk);
      rdc(8'h27, 8'hff, 8'h00);
      @(posedge clk) want <= ~s[0];
      repeat (16) @(posedge clk);
      wr(8'h27, 8'h00);
      repeat (640) @(posedge clk);
      rdc(8'h27, 8'h00, 8'h00);
      `CHK(rv inside {8'h0a, 8'h0b}, 1'b1)
    end
    $display("test gated done");
    report_and_stop;
  end
endmodule
bind pa_core pa_core_checker i_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata_ff(rdata_ff), .main_timer_wrap(main_timer_wrap), .periodic_tick_ff(periodic_tick_ff),
  .capture4_compare5_select_ff(capture4_compare5_select_ff), .main_overflow_irq_ff(main_overflow_irq_ff),
  .periodic_irq_ff(periodic_irq_ff));
